// File: verilog/gmrb_regs.sv
`timescale 1ns/1ps
module gmrb_regs
   import gmrb_pkg::*;
#(
   parameter logic [7:0] KIND_ID  = 8'h3C, // arbitrary identity value
   parameter logic [3:0] REV_MAJ  = 4'h1,
   parameter logic [3:0] REV_SUB  = 4'h0
)(
   // clock and reset
   input  wire  logic                          hclk,
   input  wire  logic                          hresetn,
   // ahb-lite slave
   input  wire  logic                          hsel,
   input  wire  logic [31:0]                   haddr,
   input  wire  logic [1:0]                    htrans,
   input  wire  logic                          hwrite,
   input  wire  logic [2:0]                    hsize,
   input  wire  logic [31:0]                   hwdata,
   input  wire  logic                          hready,
   output logic                                hreadyout,
   output logic                                hresp,
   output logic [31:0]                         hrdata,
   // line state from the field side
   input  wire  logic                          line_one_ok,
   input  wire  logic                          line_two_ok,
   input  wire  logic                          line_override_flag,
   input  wire  logic                          host_err_pulse,
   input  wire  logic                          field_err_pulse,
   // configuration to the gateway
   output logic [1:0]                          line_select,
   output logic                                mains_freq_sel,
   output logic [2*gmrb_pkg::REP_NUM-1:0]      rep_map,
   output logic [2:0]                          repeater_count,
   output logic [1:0]                          target_slave,
   output logic                                diagnostic_flag,
   output logic [7:0]                          station_address,
   output logic [2:0]                          line_rate_index,
   output logic [1:0]                          frame_format_index,
   // command pulses
   output logic                                restart_slaves_cmd,
   output logic                                restart_system_cmd,
   output logic                                calib_upload_cmd,
   output logic                                calib_download_cmd,
   // interrupt
   output logic                                irq
);
   import gmrb_pkg::*;

   logic                   rd_pend_q;
   logic                   wr_pend_q;
   logic [IDX_W-1:0]       rd_idx_q;
   logic [IDX_W-1:0]       wr_idx_q;
   logic [31:0]            hrdata_q;
   logic [15:0]            rd_word;
   logic [1:0]             line_sel_q;
   logic                   freq_q;
   logic [1:0]             map_q [REP_NUM];
   logic [2:0]             rep_cnt_q;
   logic [1:0]             slv_q;
   logic                   diag_q;
   logic [7:0]             addr_q;
   logic [2:0]             baud_q;
   logic [1:0]             fmt_q;
   logic [15:0]            cnt_q [2];
   logic [1:0]             err_evt;
   logic [1:0]             cnt_clr;
   logic [3:0]             cmd_q;
   logic [IRQ_W-1:0]       irq_stat_q;
   logic [IRQ_W-1:0]       irq_mask_q;
   logic [IRQ_W-1:0]       irq_evt;
   logic [IRQ_W-1:0]       irq_w1c;
   logic                   line1_q;
   logic                   line2_q;
   logic                   addr_take;
   logic                   wr_setup;
   logic                   wr_rep;
   logic                   wr_stat;
   logic                   wr_addr;
   logic                   wr_baud;
   logic                   wr_fmt;

   // address phase is taken only while the bus is ready; reads get one wait state
   assign addr_take = hsel && htrans[1] && hready;
   assign hreadyout = !rd_pend_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // phase tracking; haddr bits above the index are not decoded, so the map aliases
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         rd_idx_q  <= '0;
         wr_idx_q  <= '0;
      end
      else
      begin
         rd_pend_q <= addr_take && !hwrite;
         wr_pend_q <= addr_take && hwrite;
         if (addr_take)
         begin
            rd_idx_q <= haddr[IDX_W+1:2];
            wr_idx_q <= haddr[IDX_W+1:2];
         end
      end
   end

   // write strobes in the data phase; only whole-word accesses are expected
   assign wr_setup = wr_pend_q && (wr_idx_q == IDX_SETUP);
   assign wr_rep   = wr_pend_q && (wr_idx_q == IDX_REP);
   assign wr_stat  = wr_pend_q && (wr_idx_q == IDX_STAT);
   assign wr_addr  = wr_pend_q && (wr_idx_q == IDX_ADDR);
   assign wr_baud  = wr_pend_q && (wr_idx_q == IDX_BAUD);
   assign wr_fmt   = wr_pend_q && (wr_idx_q == IDX_FMT);
   assign cnt_clr  = {wr_pend_q && (wr_idx_q == IDX_FERR), wr_pend_q && (wr_idx_q == IDX_HERR)};
   assign irq_w1c  = (wr_pend_q && (wr_idx_q == IDX_IRQ_STAT)) ? hwdata[IRQ_W-1:0] : '0;

   // setup word: line choice and mains frequency
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line_sel_q <= RST_LINE_SEL;
         freq_q     <= 1'b0;
      end
      else if (wr_setup)
      begin
         line_sel_q <= hwdata[SETUP_SEL_LSB+1:SETUP_SEL_LSB];
         freq_q     <= hwdata[SETUP_FREQ];
      end
   end

   // repeater fields, each one stored on its own so that duplicates are legal
   genvar gi;
   generate
      for (gi = 0; gi < REP_NUM; gi++)
      begin : g_rep
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               map_q[gi] <= 2'h0;
            else if (wr_rep)
               map_q[gi] <= hwdata[gi*REP_MAP_STRIDE+1 -: 2];
         end
         assign rep_map[2*gi+1:2*gi] = map_q[gi];
      end
   endgenerate

   // installed repeater count
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rep_cnt_q <= 3'h0;
      else if (wr_rep)
         rep_cnt_q <= hwdata[REP_CNT_LSB+2:REP_CNT_LSB];
   end

   // status word: slave selector, diagnostic flag, one-cycle command pulses
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         slv_q  <= 2'h0;
         diag_q <= 1'b0;
         cmd_q  <= 4'h0;
      end
      else
      begin
         cmd_q <= wr_stat ? hwdata[STAT_DC:STAT_RS] : 4'h0;
         if (wr_stat)
         begin
            slv_q  <= hwdata[STAT_SLV_LSB+1:STAT_SLV_LSB];
            diag_q <= hwdata[STAT_DM];
         end
      end
   end

   // serial link settings; out-of-range station addresses are dropped
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_q <= RST_ADDR;
         baud_q <= RST_BAUD;
         fmt_q  <= RST_FMT;
      end
      else
      begin
         if (wr_addr && (hwdata[7:0] >= ADDR_MIN) && (hwdata[7:0] <= ADDR_MAX))
            addr_q <= hwdata[7:0];
         if (wr_baud)
            baud_q <= hwdata[2:0];
         if (wr_fmt)
            fmt_q <= hwdata[1:0];
      end
   end

   // error counters saturate; an error in the clearing cycle still counts
   assign err_evt = {field_err_pulse, host_err_pulse};
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_cnt
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               cnt_q[gi] <= 16'h0000;
            else if (cnt_clr[gi])
               cnt_q[gi] <= err_evt[gi] ? 16'h0001 : 16'h0000;
            else if (err_evt[gi] && (cnt_q[gi] != CNT_MAX))
               cnt_q[gi] <= cnt_q[gi] + 16'h0001;
         end
      end
   endgenerate

   // line-loss detection and sticky interrupt status, set wins over clear
   assign irq_evt = {line2_q && !line_two_ok, line1_q && !line_one_ok,
                     field_err_pulse, host_err_pulse};
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line1_q    <= 1'b0;
         line2_q    <= 1'b0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end
      else
      begin
         line1_q    <= line_one_ok;
         line2_q    <= line_two_ok;
         irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_evt;
         if (wr_pend_q && (wr_idx_q == IDX_IRQ_MASK))
            irq_mask_q <= hwdata[IRQ_W-1:0];
      end
   end

   // read mux; command bits read back as zero
   always_comb
   begin
      rd_word = 16'h0000;
      case (rd_idx_q)
         IDX_KIND:     rd_word = {8'h00, KIND_ID};
         IDX_REV:      rd_word = {8'h00, REV_MAJ, REV_SUB};
         IDX_SETUP:    rd_word = {13'h0000, freq_q, line_sel_q};
         IDX_REP:      rd_word = {1'b0, rep_cnt_q, 1'b0, map_q[3], 1'b0, map_q[2],
                                  1'b0, map_q[1], 1'b0, map_q[0]};
         IDX_STAT:     rd_word = {2'h0, line_override_flag, diag_q, 4'h0,
                                  line_two_ok, line_one_ok, 4'h0, slv_q};
         IDX_ADDR:     rd_word = {8'h00, addr_q};
         IDX_BAUD:     rd_word = {13'h0000, baud_q};
         IDX_FMT:      rd_word = {14'h0000, fmt_q};
         IDX_HERR:     rd_word = cnt_q[0];
         IDX_FERR:     rd_word = cnt_q[1];
         IDX_IRQ_STAT: rd_word = {12'h000, irq_stat_q};
         IDX_IRQ_MASK: rd_word = {12'h000, irq_mask_q};
         default:      rd_word = 16'h0000;
      endcase
   end

   // read data is latched in the wait cycle, so a write just before is seen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (rd_pend_q)
         hrdata_q <= {16'h0000, rd_word};
   end

   // outputs
   assign line_select        = line_sel_q;
   assign mains_freq_sel     = freq_q;
   assign repeater_count     = rep_cnt_q;
   assign target_slave       = slv_q;
   assign diagnostic_flag    = diag_q;
   assign station_address    = addr_q;
   assign line_rate_index    = baud_q;
   assign frame_format_index = fmt_q;
   assign restart_slaves_cmd = cmd_q[0];
   assign restart_system_cmd = cmd_q[1];
   assign calib_upload_cmd   = cmd_q[2];
   assign calib_download_cmd = cmd_q[3];
   assign irq                = |(irq_stat_q & irq_mask_q);

   a_rsvd_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_q && (rd_idx_q == 12'h0405) |=> (hrdata == 32'h0000_0000) && hreadyout)
      else $error("reserved word did not read zero");

   a_kind_read: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite && (haddr[IDX_W+1:2] == IDX_KIND) ##1 1'b1
      |=> (hrdata[15:0] == {8'h00, KIND_ID}))
      else $error("kind word read wrong");

   a_rev_read: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_q && (rd_idx_q == IDX_REV) |=> (hrdata[7:0] == {REV_MAJ, REV_SUB}))
      else $error("revision word read wrong");

   a_line_sel_wr: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_setup |=> (line_select == $past(hwdata[1:0])) && (mains_freq_sel == $past(hwdata[2])))
      else $error("setup word not stored");

   a_rep_map_wr: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_rep |=> (rep_map == {$past(hwdata[10:9]), $past(hwdata[7:6]),
                              $past(hwdata[4:3]), $past(hwdata[1:0])}))
      else $error("repeater map not stored");

   a_rep_cnt_wr: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_rep |=> (repeater_count == $past(hwdata[14:12])))
      else $error("repeater count not stored");

   a_line_state_rd: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_q && (rd_idx_q == IDX_STAT)
      |=> (hrdata[7:6] == {$past(line_two_ok), $past(line_one_ok)}))
      else $error("line state read wrong");

   a_cmd_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_stat |=> (cmd_q == $past(hwdata[STAT_DC:STAT_RS])))
      else $error("command pulses do not match the write");

   a_cmd_origin: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_q != 4'h0) |-> $past(wr_stat))
      else $error("command pulse without a status write");

   a_addr_range: assert property (@(posedge hclk) disable iff (!hresetn)
      (station_address >= ADDR_MIN) && (station_address <= ADDR_MAX))
      else $error("station address out of range");

   a_cnt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      cnt_clr[0] && !host_err_pulse |=> (cnt_q[0] == 16'h0000))
      else $error("error counter not cleared");

endmodule : gmrb_regs

// File: verilog/gmrb_pkg.sv
package gmrb_pkg;

   // word index of each register (byte address is four times the index)
   localparam int          IDX_W        = 12;
   localparam logic [11:0] IDX_KIND     = 12'h0400;
   localparam logic [11:0] IDX_REV      = 12'h0401;
   localparam logic [11:0] IDX_SETUP    = 12'h0402;
   localparam logic [11:0] IDX_REP      = 12'h0403;
   localparam logic [11:0] IDX_STAT     = 12'h0404;
   localparam logic [11:0] IDX_ADDR     = 12'h0408;
   localparam logic [11:0] IDX_BAUD     = 12'h0409;
   localparam logic [11:0] IDX_FMT      = 12'h040A;
   localparam logic [11:0] IDX_HERR     = 12'h040E;
   localparam logic [11:0] IDX_FERR     = 12'h040F;
   localparam logic [11:0] IDX_IRQ_STAT = 12'h0500;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h0501;

   // setup word fields
   localparam int SETUP_SEL_LSB = 0;
   localparam int SETUP_FREQ    = 2;

   // repeater word fields
   localparam int REP_NUM        = 4;
   localparam int REP_MAP_STRIDE = 3;
   localparam int REP_CNT_LSB    = 12;

   // status and command word fields
   localparam int STAT_SLV_LSB = 0;
   localparam int STAT_LINE1   = 6;
   localparam int STAT_LINE2   = 7;
   localparam int STAT_RS      = 8;
   localparam int STAT_RA      = 9;
   localparam int STAT_UC      = 10;
   localparam int STAT_DC      = 11;
   localparam int STAT_DM      = 12;
   localparam int STAT_LO      = 13;

   // revision word fields
   localparam int REV_SUB_LSB = 0;
   localparam int REV_MAJ_LSB = 4;

   // reset values and limits
   localparam logic [1:0]  RST_LINE_SEL = 2'h0;
   localparam logic [7:0]  RST_ADDR     = 8'h01;
   localparam logic [2:0]  RST_BAUD     = 3'h1;
   localparam logic [1:0]  RST_FMT      = 2'h0;
   localparam logic [7:0]  ADDR_MIN     = 8'h01;
   localparam logic [7:0]  ADDR_MAX     = 8'hF7;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;

   // interrupt status bits
   localparam int IRQ_W       = 4;
   localparam int IRQ_HERR    = 0;
   localparam int IRQ_FERR    = 1;
   localparam int IRQ_L1_LOST = 2;
   localparam int IRQ_L2_LOST = 3;

endpackage : gmrb_pkg

// File: tb/gmrb_field_model.sv
`timescale 1ns/1ps
// field-side stand-in: line health, override and error events for the register bank
module gmrb_field_model
(
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // requests from the bench
   input  wire logic line_one_req,
   input  wire logic line_two_req,
   input  wire logic override_req,
   input  wire logic herr_req,
   input  wire logic ferr_req,
   // field side levels and pulses
   output logic      line_one_ok,
   output logic      line_two_ok,
   output logic      line_override_flag,
   output logic      host_err_pulse,
   output logic      field_err_pulse
);
   // registered so every change lands just after an edge; one error per cycle held high
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line_one_ok        <= 1'b0;
         line_two_ok        <= 1'b0;
         line_override_flag <= 1'b0;
         host_err_pulse     <= 1'b0;
         field_err_pulse    <= 1'b0;
      end
      else
      begin
         line_one_ok        <= line_one_req;
         line_two_ok        <= line_two_req;
         line_override_flag <= override_req;
         host_err_pulse     <= herr_req;
         field_err_pulse    <= ferr_req;
      end
   end
endmodule : gmrb_field_model

// File: tb/gmrb_regs_test.sv
`timescale 1ns/1ps
module gmrb_regs_test;
   import gmrb_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        l1_req, l2_req, lo_req, herr_req, ferr_req;
   logic        line_one_ok, line_two_ok, line_override_flag, host_err_pulse, field_err_pulse;
   logic        mains_freq_sel, diagnostic_flag, rs_cmd, ra_cmd, uc_cmd, dc_cmd;
   logic [1:0]  htrans, line_select, target_slave, frame_format_index;
   logic [2:0]  hsize, repeater_count, line_rate_index, cnt;
   logic [7:0]  rep_map, station_address, map;
   logic [15:0] wv;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [11:0] rsv [9] = '{12'h405, 12'h406, 12'h407, 12'h40B, 12'h40C, 12'h40D,
                            12'h410, 12'h41F, 12'h7FF};
   logic [7:0]  sa_w [4] = '{8'hF7, 8'hF8, 8'h00, 8'h01};
   logic [7:0]  sa_e [4] = '{8'hF7, 8'hF7, 8'hF7, 8'h01};
   int          bad_count = 0;
   int          checks = 0;

   // identity values below are arbitrary
   gmrb_regs #(.KIND_ID(8'hA5), .REV_MAJ(4'h2), .REV_SUB(4'h3)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .line_one_ok(line_one_ok), .line_two_ok(line_two_ok),
      .line_override_flag(line_override_flag), .host_err_pulse(host_err_pulse),
      .field_err_pulse(field_err_pulse), .line_select(line_select),
      .mains_freq_sel(mains_freq_sel), .rep_map(rep_map), .repeater_count(repeater_count),
      .target_slave(target_slave), .diagnostic_flag(diagnostic_flag),
      .station_address(station_address), .line_rate_index(line_rate_index),
      .frame_format_index(frame_format_index), .restart_slaves_cmd(rs_cmd),
      .restart_system_cmd(ra_cmd), .calib_upload_cmd(uc_cmd), .calib_download_cmd(dc_cmd),
      .irq(irq));

   gmrb_field_model u_field (
      .hclk(hclk), .hresetn(hresetn), .line_one_req(l1_req), .line_two_req(l2_req),
      .override_req(lo_req), .herr_req(herr_req), .ferr_req(ferr_req),
      .line_one_ok(line_one_ok), .line_two_ok(line_two_ok),
      .line_override_flag(line_override_flag), .host_err_pulse(host_err_pulse),
      .field_err_pulse(field_err_pulse));

   // free-running bus clock, 10 ns period
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic final_report;
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk

   // hready and read data are looked at in the low half of the clock, where they are
   // settled, and the transfer moves on at the next rising edge; a dead slave ends the run
   task automatic wait_ready(output logic [31:0] data);
      int   n;
      logic rdy;
      n    = 0;
      rdy  = 1'b0;
      data = '0;
      do
      begin
         @(negedge hclk);
         rdy  = (hreadyout === 1'b1);
         data = hrdata;
         @(posedge hclk);
         n++;
      end
      while (!rdy && n < 20);
      if (!rdy)
      begin
         bad_count++;
         final_report();
      end
   endtask : wait_ready

   // one single word transfer: address phase, then data phase, both held until hready
   task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {18'h0, idx, 2'b00};
      wait_ready(rd);
      htrans <= 2'b00;
      hwdata <= {16'h0, wd};
      wait_ready(rd);
   endtask : bus

   task automatic wr(input logic [11:0] idx, input logic [15:0] wd);
      bus(1'b1, idx, wd);
   endtask : wr

   task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 16'h0);
      chk(rd, exp);
   endtask : rdc

   // main sequence; all inputs set at time zero, reset held two cycles
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {herr_req, ferr_req} = 2'b00;
      {l1_req, l2_req, lo_req} = 3'b111;
      hsize = 3'b010;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(IDX_ADDR, 32'h0000_0001);
      rdc(IDX_BAUD, 32'h0000_0001);
      wr(IDX_KIND, 16'hFFFF);
      rdc(IDX_KIND, 32'h0000_00A5);
      wr(IDX_REV, 16'hFFFF);
      rdc(IDX_REV, 32'h0000_0023);
      // line select and mains frequency, reserved bits written high
      for (int i = 0; i < 6; i++)
      begin
         wv = {13'h0, i >= 3, 2'(i % 3)};
         wr(IDX_SETUP, wv | 16'hFFF8);
         rdc(IDX_SETUP, {16'h0, wv});
         chk({29'h0, mains_freq_sel, line_select}, {16'h0, wv});
      end
      // all four on one slave per code, then four distinct slaves
      for (int i = 0; i < 5; i++)
      begin
         map = (i == 4) ? 8'hE4 : {4{2'(i)}};
         cnt = (i == 4) ? 3'h7 : 3'(i);
         wv = {1'b0, cnt, 1'b0, map[7:6], 1'b0, map[5:4], 1'b0, map[3:2], 1'b0, map[1:0]};
         wr(IDX_REP, wv | 16'h8924);
         rdc(IDX_REP, {16'h0, wv});
         chk({21'h0, rep_map, repeater_count}, {21'h0, map, cnt});
      end
      // each command bit alone, read-only and reserved bits written high
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_STAT, 16'hE0FC | (16'h0100 << i) | {3'h0, i[0], 10'h0, 2'(i)});
         #1;
         chk({28'h0, dc_cmd, uc_cmd, ra_cmd, rs_cmd}, 32'h1 << i);
         @(posedge hclk);
         #1;
         chk({28'h0, dc_cmd, uc_cmd, ra_cmd, rs_cmd}, 32'h0);
         @(posedge hclk);
         rdc(IDX_STAT, {18'h0, 1'b1, i[0], 6'h03, 4'h0, 2'(i)});
         chk({29'h0, diagnostic_flag, target_slave}, {29'h0, i[0], 2'(i)});
      end
      // station address: out-of-range values keep the old one
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_ADDR, {8'h0, sa_w[i]});
         rdc(IDX_ADDR, {24'h0, sa_e[i]});
         chk({24'h0, station_address}, {24'h0, sa_e[i]});
      end
      // baud index only 0..5 is ever written by the host
      // host keeps the index legal
      for (int i = 0; i < 6; i++)
      begin
         wr(IDX_BAUD, 16'(i));
         rdc(IDX_BAUD, 32'(i));
         chk({29'h0, line_rate_index}, 32'(i));
         wr(IDX_FMT, 16'(i % 4));
         rdc(IDX_FMT, 32'(i % 4));
         chk({30'h0, frame_format_index}, 32'(i % 4));
      end
      // reserved and unmapped words read zero and ignore writes
      for (int i = 0; i < 9; i++)
      begin
         wr(rsv[i], 16'hFFFF);
         rdc(rsv[i], 32'h0);
      end
      rdc(IDX_SETUP, 32'h0000_0006);
      rdc(IDX_ADDR, 32'h0000_0001);
      rdc(IDX_FMT, 32'h0000_0001);
      // three host errors, two field errors, line two lost
      herr_req <= 1'b1;
      ferr_req <= 1'b1;
      l2_req   <= 1'b0;
      repeat (2) @(posedge hclk);
      ferr_req <= 1'b0;
      @(posedge hclk);
      herr_req <= 1'b0;
      repeat (3) @(posedge hclk);
      rdc(IDX_HERR, 32'h0000_0003);
      rdc(IDX_FERR, 32'h0000_0002);
      rdc(IDX_IRQ_STAT, 32'h0000_000B);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_IRQ_MASK, 16'h0008);
      #1;
      chk({31'h0, irq}, 32'h1);
      @(posedge hclk);
      wr(IDX_IRQ_STAT, 16'h0008);
      #1;
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      rdc(IDX_IRQ_STAT, 32'h0000_0003);
      wr(IDX_HERR, 16'h1234);
      wr(IDX_FERR, 16'h0000);
      rdc(IDX_HERR, 32'h0);
      rdc(IDX_FERR, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      final_report();
   end
endmodule : gmrb_regs_test
